// ==== bench/tb_clk_ctrl.sv ====
// self-checking bench for the clock control block
`timescale 1ns/1ps
module tb_clk_ctrl;
  import clk_ctrl_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  axi_req_t    q = '0;
  axi_rsp_t    p;
  logic [5:0]  tk = 6'h00;
  logic [5:0]  st = 6'h3e;
  kticks_t     tks;
  kticks_t     t;
  logic [5:0]  oe;
  logic [1:0]  act;
  logic [3:0]  wk;
  logic [31:0] d;
  logic [1:0]  r;
  mode_t       md = MODE_RUN;
  logic        ain = 1'b0;
  logic        lin = 1'b0;
  int          n_errors = 0;
  int          checked = 0;
  int          nb0 = 0;
  int          nb2 = 0;
  int          nst = 0;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end

  always #4 aclk = ~aclk;

  clk_ctrl #(.PLL_KHZ(64000)) dut (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .axi_in             (q),
    .axi_out            (p),
    .src_tick           (tk),
    .src_stable         (st),
    .pll_q_output       (1'b0),
    .pll_p_output       (1'b0),
    .cpu_mode           (md),
    .audio_ext_clock_in (ain),
    .lptim_ext_in       (lin),
    .ticks              (tks),
    .osc_enable         (oe),
    .sys_src_active     (act),
    .wake_ok            (wk)
  );

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    int i;
    @(posedge aclk);
    q.awaddr  <= a;
    q.awvalid <= 1'b1;
    q.wdata   <= dat;
    q.wstrb   <= 4'hf;
    q.wvalid  <= 1'b1;
    q.bready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (q.awvalid && p.awready === 1'b1) q.awvalid <= 1'b0;
      if (q.wvalid && p.wready === 1'b1) q.wvalid <= 1'b0;
      if (p.bvalid === 1'b1)
      begin
        rsp = p.bresp;
        q.bready <= 1'b0;
        break;
      end
    end
    if (i == 40)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    int i;
    @(posedge aclk);
    q.araddr  <= a;
    q.arvalid <= 1'b1;
    q.rready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (q.arvalid && p.arready === 1'b1) q.arvalid <= 1'b0;
      if (p.rvalid === 1'b1)
      begin
        dat = p.rdata;
        rsp = p.rresp;
        q.rready <= 1'b0;
        break;
      end
    end
    if (i == 40)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : rd

  // one source pulse, then the tick outputs of the following cycle
  task automatic pulse(input int k);
    @(posedge aclk);
    tk[k] <= 1'b1;
    @(posedge aclk);
    tk[k] <= 1'b0;
    @(posedge aclk);
    t = tks;
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic boot_state;
    `CHK("osc_en", 6'h02, oe);
    `CHK("sys_act", 2'h1, act);
    rd(OFF_OSC, d, r);
    `CHK("osc_reg", 32'h00000502, d);
    rd(OFF_SYS, d, r);
    `CHK("sys_reg", 4'h5, d[3:0]);
    rd(12'h020, d, r);
    `CHK("unmapped", 2'h2, r);
  endtask : boot_state

  task automatic source_switch;
    wr(OFF_OSC, 32'h0000051b, r);
    `CHK("osc_on", 6'h1b, oe);
    wr(OFF_SYS, 32'h00000003, r);
    `CHK("ceiling", 2'h2, r);
    wr(OFF_SYS, 32'h00000000, r);
    repeat (3) @(posedge aclk);
    `CHK("hold", 2'h1, act);
    rd(OFF_SYS, d, r);
    `CHK("pending", 1'b1, d[SYS_PEND_BIT]);
    st[0] <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("switch", 2'h0, act);
    wr(OFF_SYS, 32'h00001001, r);
    repeat (2) @(posedge aclk);
    `CHK("back", 2'h1, act);
  endtask : source_switch

  task automatic bus_prescale;
    repeat (16)
    begin
      pulse(SRC_MULTI);
      nb0 += t.bus[B_AHB1];
      nb2 += t.bus[B_APB1];
      nst += t.system_tick_timer_ref;
    end
    `CHK("ahb1", 16, nb0);
    `CHK("apb1", 8, nb2);
    `CHK("system_tick_timer", 2, nst);
    pulse(SRC_ISLOW);
    `CHK("wdog", 1'b1, t.watchdog);
    pulse(SRC_FAST);
    `CHK("sys_other", 1'b0, t.sys);
  endtask : bus_prescale

  // rng islow, adc ahb/div, serial fast, twowire fast, audio pin, lptim pin, calendar islow
  task automatic kernel_run;
    int n;
    n = 0;
    wr(OFF_KSEL, 32'h0006225a, r);
    rd(OFF_KSEL, d, r);
    `CHK("ksel", 32'h0006225a, d);
    `CHK("wake", 4'hf, wk);
    wr(OFF_MISC, 32'h00000010, r);
    pulse(SRC_MULTI);
    `CHK("adc_div1", 1'b1, t.kern[K_ADC]);
    wr(OFF_MISC, 32'h00000011, r);
    repeat (4)
    begin
      pulse(SRC_MULTI);
      n += t.kern[K_ADC];
    end
    `CHK("adc_div2", 2, n);
    pulse(SRC_ISLOW);
    `CHK("dac", 1'b1, t.dac);
    `CHK("kern_slow", 7'h41, t.kern);
  endtask : kernel_run

  task automatic kernel_stop;
    int n;
    n = 0;
    md <= MODE_STOP;
    pulse(SRC_FAST);
    `CHK("stop_fast", 7'h0c, t.kern);
    `CHK("stop_sys", 1'b0, t.sys);
    pulse(SRC_MULTI);
    `CHK("stop_bus", 4'h0, t.bus);
    pulse(SRC_ISLOW);
    `CHK("stop_slow", 7'h41, t.kern);
    ain <= 1'b1;
    lin <= 1'b1;
    repeat (8)
    begin
      @(posedge aclk);
      n += tks.kern[K_AUD] + tks.kern[K_LPT];
    end
    `CHK("pins", 2, n);
    md <= MODE_RUN;
  endtask : kernel_stop

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    boot_state();
    source_switch();
    bus_prescale();
    kernel_run();
    kernel_stop();
    print_verdict();
  end
endmodule : tb_clk_ctrl

// ==== shared/clk_ctrl_pkg.sv ====
// clock control: register layout, source codes, carrier types
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // sizes and indices
  // ----------------------------------------------------------------
  localparam int NSRC  = 6;
  localparam int NBUS  = 4;
  localparam int NKMUX = 7;
  localparam int NCAND = 8;
  // oscillator vector index; the low four double as system select codes
  localparam int SRC_FAST  = 0;
  localparam int SRC_MULTI = 1;
  localparam int SRC_EXTF  = 2;
  localparam int SRC_PLL   = 3;
  localparam int SRC_ISLOW = 4;
  localparam int SRC_ESLOW = 5;
  localparam int B_AHB1 = 0;
  localparam int B_AHB3 = 1;
  localparam int B_APB1 = 2;
  localparam int B_APB2 = 3;
  localparam int K_RNG = 0;
  localparam int K_ADC = 1;
  localparam int K_SER = 2;
  localparam int K_TWI = 3;
  localparam int K_AUD = 4;
  localparam int K_LPT = 5;
  localparam int K_CAL = 6;
  localparam int W_SER = 0;
  localparam int W_TWI = 1;
  localparam int W_LPT = 2;
  localparam int W_CAL = 3;

  // ----------------------------------------------------------------
  // rates and dividers
  // ----------------------------------------------------------------
  localparam int unsigned FAST_KHZ    = 16000;
  localparam int unsigned EXTF_KHZ    = 32000;
  localparam int unsigned BUS_MAX_KHZ = 48000;
  localparam int unsigned ISLOW_HZ    = 32000;
  localparam int unsigned ESLOW_HZ    = 32768;
  // multispeed range code -> kHz, code 5 is 4 MHz
  localparam logic [7:0][15:0] MSI_KHZ = {16'hbb80, 16'h3e80, 16'h0fa0, 16'h07d0,
                                          16'h03e8, 16'h0190, 16'h00c8, 16'h0064};
  localparam int EXTF_CAL_DIV = 32;
  localparam int SYSTEM_TICK_TIMER_DIV  = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_OSC  = 12'h000;
  localparam logic [11:0] OFF_SYS  = 12'h004;
  localparam logic [11:0] OFF_KSEL = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_MISC = 12'h010;
  localparam int OSC_ON_LSB      = 0;
  localparam int MSI_RNG_LSB     = 8;
  localparam int SYS_SEL_LSB     = 0;
  localparam int SYS_ACT_LSB     = 2;
  localparam int SYS_PRE_LSB     = 4;
  localparam int SYS_PRE_STRIDE  = 4;
  localparam int SYS_PEND_BIT    = 20;
  localparam int KSEL_W          = 3;
  localparam int MISC_ADCDIV_LSB = 0;
  localparam int MISC_DACSH_BIT  = 4;
  localparam int MISC_STCPU_BIT  = 5;
  localparam int MISC_SE_LSB     = 8;
  localparam int STAT_RDY_LSB    = 0;
  localparam int STAT_WAKE_LSB   = 8;
  localparam int STAT_MODE_LSB   = 12;
  localparam logic [NSRC-1:0] RST_OSC_ON  = 6'h02;
  localparam logic [2:0]      RST_MSI_RNG = 3'h5;
  localparam logic [1:0]      SYS_MULTI   = 2'h1;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_STOP} mode_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic             sys;
    logic [NBUS-1:0]  bus;
    logic [NKMUX-1:0] kern;
    logic             dac;
    logic             watchdog;
    logic             system_tick_timer_ref;
  } kticks_t;

endpackage : clk_ctrl_pkg

// ==== verilog/clk_ctrl.sv ====
// clock source selection, bus prescalers and kernel clock muxes
`timescale 1ns/1ps
module clk_ctrl #(
  parameter int unsigned PLL_KHZ = 48000
) (
  input  logic                               aclk,
  input  logic                               aresetn,
  input  clk_ctrl_pkg::axi_req_t             axi_in,
  output clk_ctrl_pkg::axi_rsp_t             axi_out,
  input  logic [clk_ctrl_pkg::NSRC-1:0]      src_tick,
  input  logic [clk_ctrl_pkg::NSRC-1:0]      src_stable,
  input  logic                               pll_q_output,
  input  logic                               pll_p_output,
  input  clk_ctrl_pkg::mode_t                cpu_mode,
  input  logic                               audio_ext_clock_in,
  input  logic                               lptim_ext_in,
  output clk_ctrl_pkg::kticks_t              ticks,
  output logic [clk_ctrl_pkg::NSRC-1:0]      osc_enable,
  output logic [1:0]                         sys_src_active,
  output logic [3:0]                         wake_ok
);
  import clk_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0]                   aud_sync;
    logic                         aud_lvl;
    logic [2:0]                   lpt_sync;
    logic                         lpt_lvl;
    logic [NSRC-1:0]              osc_on;
    logic [2:0]                   msi_rng;
    logic [1:0]                   sys_req;
    logic [1:0]                   sys_act;
    logic [NBUS-1:0][2:0]         pre;
    logic [NBUS-1:0][6:0]         pre_cnt;
    logic [NKMUX-1:0][2:0]        ksel_req;
    logic [NKMUX-1:0][2:0]        ksel_act;
    logic [1:0]                   adc_div;
    logic [1:0]                   adc_cnt;
    logic                         dac_sh;
    logic                         st_cpu;
    logic [2:0]                   st_cnt;
    logic [2:0]                   sleep_en;
    logic [4:0]                   extf_cnt;
    kticks_t                      ticks;
    logic [3:0]                   wake;
    logic                         aw_hold;
    logic                         w_hold;
    logic [11:0]                  awaddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    axi_rsp_t                     rsp;
  } state_t;

  state_t                       s_q;
  state_t                       s_d;
  logic [NSRC-1:0]              rdy;
  logic [NSRC-1:0]              live;
  logic                         run;
  logic                         sys_t;
  logic [NBUS-1:0]              bus_t;
  logic                         adc_t;
  logic                         cal_t;
  logic                         st_t;
  logic                         aud_edge;
  logic                         lpt_edge;
  logic [1:0]                   adc_lim;
  logic [6:0]                   pre_lim;
  logic [NKMUX-1:0][NCAND-1:0]  c_tick;
  logic [NKMUX-1:0][NCAND-1:0]  c_ok;
  logic [NKMUX-1:0]             kt;
  logic [32:0]                  rd;
  logic [31:0]                  mask;
  logic [31:0]                  merged;
  logic [NBUS-1:0][2:0]         npre;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when any bus would run above its ceiling
  function automatic logic over_max(input logic [1:0] sel, input logic [2:0] rng,
                                    input logic [NBUS-1:0][2:0] pr);
    int unsigned khz;
    over_max = 1'b0;
    case (sel)
      2'h0: khz = FAST_KHZ;
      2'h1: khz = 32'(MSI_KHZ[rng]);
      2'h2: khz = EXTF_KHZ;
      default: khz = PLL_KHZ;
    endcase
    for (int i = 0; i < NBUS; i++)
      if ((khz >> pr[i]) > BUS_MAX_KHZ)
        over_max = 1'b1;
  endfunction : over_max

  // register read mux; top bit flags an unmapped address
  function automatic logic [32:0] reg_rd(input state_t st, input logic [11:0] a,
                                         input logic [NSRC-1:0] r, input mode_t md);
    logic [31:0] d;
    logic        err;
    d = '0;
    err = 1'b0;
    if (a[11:2] == OFF_OSC[11:2])
    begin
      d[OSC_ON_LSB+:NSRC] = st.osc_on;
      d[MSI_RNG_LSB+:3] = st.msi_rng;
    end
    else if (a[11:2] == OFF_SYS[11:2])
    begin
      d[SYS_SEL_LSB+:2] = st.sys_req;
      d[SYS_ACT_LSB+:2] = st.sys_act;
      for (int i = 0; i < NBUS; i++)
        d[SYS_PRE_LSB+SYS_PRE_STRIDE*i+:3] = st.pre[i];
      d[SYS_PEND_BIT] = (st.sys_req != st.sys_act);
    end
    else if (a[11:2] == OFF_KSEL[11:2])
    begin
      for (int m = 0; m < NKMUX; m++)
        d[KSEL_W*m+:KSEL_W] = st.ksel_req[m];
    end
    else if (a[11:2] == OFF_MISC[11:2])
    begin
      d[MISC_ADCDIV_LSB+:2] = st.adc_div;
      d[MISC_DACSH_BIT] = st.dac_sh;
      d[MISC_STCPU_BIT] = st.st_cpu;
      d[MISC_SE_LSB+:3] = st.sleep_en;
    end
    else if (a[11:2] == OFF_STAT[11:2])
    begin
      d[STAT_RDY_LSB+:NSRC] = r;
      d[STAT_WAKE_LSB+:4] = st.wake;
      d[STAT_MODE_LSB+:2] = md;
    end
    else
      err = 1'b1;
    reg_rd = {err, d};
  endfunction : reg_rd

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    rd = '0;
    mask = '0;
    merged = '0;
    npre = s_q.pre;
    bus_t = '0;
    adc_t = 1'b0;
    c_tick = '0;
    c_ok = '0;
    kt = '0;
    pre_lim = '0;

    // pin inputs: a change counts once stages two and three agree
    s_d.aud_sync = {s_q.aud_sync[1:0], audio_ext_clock_in};
    s_d.lpt_sync = {s_q.lpt_sync[1:0], lptim_ext_in};
    if (s_q.aud_sync[1] == s_q.aud_sync[2])
      s_d.aud_lvl = s_q.aud_sync[2];
    if (s_q.lpt_sync[1] == s_q.lpt_sync[2])
      s_d.lpt_lvl = s_q.lpt_sync[2];
    aud_edge = s_d.aud_lvl & ~s_q.aud_lvl;
    lpt_edge = s_d.lpt_lvl & ~s_q.lpt_lvl;

    // a source ticks only while switched on and stable
    rdy = s_q.osc_on & src_stable;
    live = src_tick & rdy;
    run = (cpu_mode == MODE_RUN);

    // system clock: stopped in stop mode
    sys_t = live[s_q.sys_act] & (cpu_mode != MODE_STOP);
    if (s_q.sys_req != s_q.sys_act && rdy[s_q.sys_req])
      s_d.sys_act = s_q.sys_req;

    // bus prescalers, divide by 2**code
    for (int i = 0; i < NBUS; i++)
    begin
      pre_lim = 7'((8'h01 << s_q.pre[i]) - 8'h01);
      if (sys_t)
      begin
        if (s_q.pre_cnt[i] >= pre_lim)
        begin
          s_d.pre_cnt[i] = '0;
          bus_t[i] = 1'b1;
        end
        else
          s_d.pre_cnt[i] = s_q.pre_cnt[i] + 7'h01;
      end
    end

    // converter bus-clock divider 1/2/4; divider 1 relies on ahb code 0
    adc_lim = s_q.adc_div[1] ? 2'h3 : {1'b0, s_q.adc_div[0]};
    if (bus_t[B_AHB1])
    begin
      if (s_q.adc_cnt >= adc_lim)
      begin
        s_d.adc_cnt = '0;
        adc_t = 1'b1;
      end
      else
        s_d.adc_cnt = s_q.adc_cnt + 2'h1;
    end

    // system tick reference
    if (bus_t[B_AHB1])
      s_d.st_cnt = s_q.st_cnt + 3'h1;
    st_t = bus_t[B_AHB1] & (s_q.st_cpu | (s_q.st_cnt == 3'(SYSTEM_TICK_TIMER_DIV - 1)));

    // external fast oscillator divided for the calendar
    if (live[SRC_EXTF])
      s_d.extf_cnt = s_q.extf_cnt + 5'h01;
    cal_t = live[SRC_EXTF] & (s_q.extf_cnt == 5'(EXTF_CAL_DIV - 1));

    // kernel candidates: tick and availability per select code
    c_tick[K_RNG][0] = pll_q_output;
    c_ok[K_RNG][0] = run & rdy[SRC_PLL];
    c_tick[K_RNG][1] = live[SRC_MULTI];
    c_ok[K_RNG][1] = run & rdy[SRC_MULTI];
    c_tick[K_RNG][2] = live[SRC_ISLOW];
    c_ok[K_RNG][2] = rdy[SRC_ISLOW];
    c_tick[K_RNG][3] = live[SRC_ESLOW];
    c_ok[K_RNG][3] = rdy[SRC_ESLOW];

    c_tick[K_ADC][0] = sys_t;
    c_ok[K_ADC][0] = run;
    c_tick[K_ADC][1] = live[SRC_FAST];
    c_ok[K_ADC][1] = run & rdy[SRC_FAST];
    c_tick[K_ADC][2] = pll_p_output;
    c_ok[K_ADC][2] = run & rdy[SRC_PLL];
    c_tick[K_ADC][3] = adc_t;
    c_ok[K_ADC][3] = run;

    c_tick[K_SER][0] = sys_t;
    c_ok[K_SER][0] = run;
    c_tick[K_SER][1] = live[SRC_FAST];
    c_ok[K_SER][1] = rdy[SRC_FAST];
    c_tick[K_SER][2] = live[SRC_ESLOW];
    c_ok[K_SER][2] = rdy[SRC_ESLOW];
    c_tick[K_SER][3] = bus_t[B_APB2];
    c_ok[K_SER][3] = run | (cpu_mode == MODE_SLEEP) & s_q.sleep_en[0];

    c_tick[K_TWI][0] = sys_t;
    c_ok[K_TWI][0] = run;
    c_tick[K_TWI][1] = live[SRC_FAST];
    c_ok[K_TWI][1] = rdy[SRC_FAST];
    c_tick[K_TWI][2] = bus_t[B_APB1];
    c_ok[K_TWI][2] = run | (cpu_mode == MODE_SLEEP) & s_q.sleep_en[1];

    c_tick[K_AUD][0] = live[SRC_FAST];
    c_ok[K_AUD][0] = run & rdy[SRC_FAST];
    c_tick[K_AUD][1] = pll_q_output;
    c_ok[K_AUD][1] = run & rdy[SRC_PLL];
    c_tick[K_AUD][2] = aud_edge;
    c_ok[K_AUD][2] = 1'b1;

    c_tick[K_LPT][0] = live[SRC_ISLOW];
    c_ok[K_LPT][0] = rdy[SRC_ISLOW];
    c_tick[K_LPT][1] = live[SRC_ESLOW];
    c_ok[K_LPT][1] = rdy[SRC_ESLOW];
    c_tick[K_LPT][2] = live[SRC_FAST];
    c_ok[K_LPT][2] = run & rdy[SRC_FAST];
    c_tick[K_LPT][3] = bus_t[B_APB1];
    c_ok[K_LPT][3] = run | s_q.sleep_en[2];
    c_tick[K_LPT][4] = lpt_edge;
    c_ok[K_LPT][4] = 1'b1;

    c_tick[K_CAL][0] = live[SRC_ESLOW];
    c_ok[K_CAL][0] = rdy[SRC_ESLOW];
    c_tick[K_CAL][1] = live[SRC_ISLOW];
    c_ok[K_CAL][1] = rdy[SRC_ISLOW];
    c_tick[K_CAL][2] = cal_t;
    c_ok[K_CAL][2] = rdy[SRC_EXTF] & (cpu_mode != MODE_STOP);

    // kernel muxes cut over only when the new input is usable
    for (int m = 0; m < NKMUX; m++)
    begin
      if (s_q.ksel_req[m] != s_q.ksel_act[m] && c_ok[m][s_q.ksel_req[m]])
        s_d.ksel_act[m] = s_q.ksel_req[m];
      kt[m] = c_tick[m][s_q.ksel_act[m]] & c_ok[m][s_q.ksel_act[m]];
    end

    s_d.ticks.sys = sys_t;
    s_d.ticks.bus = bus_t;
    s_d.ticks.kern = kt;
    s_d.ticks.dac = s_q.dac_sh & live[SRC_ISLOW];
    s_d.ticks.watchdog = live[SRC_ISLOW];
    s_d.ticks.system_tick_timer_ref = st_t;
    s_d.wake[W_SER] = (s_q.ksel_act[K_SER] == 3'h1) | (s_q.ksel_act[K_SER] == 3'h2);
    s_d.wake[W_TWI] = (s_q.ksel_act[K_TWI] == 3'h1);
    s_d.wake[W_LPT] = (s_q.ksel_act[K_LPT] <= 3'h1) | (s_q.ksel_act[K_LPT] == 3'h4);
    s_d.wake[W_CAL] = (s_q.ksel_act[K_CAL] <= 3'h1);

    // ----------------------------------------------------------------
    // register slave
    // ----------------------------------------------------------------
    if (axi_in.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_hold = 1'b1;
      s_d.awaddr = axi_in.awaddr;
    end
    if (axi_in.wvalid && s_q.rsp.wready)
    begin
      s_d.w_hold = 1'b1;
      s_d.wdata = axi_in.wdata;
      s_d.wstrb = axi_in.wstrb;
    end
    if (s_q.rsp.bvalid && axi_in.bready)
      s_d.rsp.bvalid = 1'b0;
    if (s_q.rsp.rvalid && axi_in.rready)
      s_d.rsp.rvalid = 1'b0;

    if (s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid)
    begin
      rd = reg_rd(s_q, s_q.awaddr, rdy, cpu_mode);
      for (int b = 0; b < 4; b++)
        mask[8*b+:8] = {8{s_q.wstrb[b]}};
      merged = (rd[31:0] & ~mask) | (s_q.wdata & mask);
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = RESP_OKAY;
      if (s_q.awaddr[11:2] == OFF_OSC[11:2])
      begin
        if (over_max(s_q.sys_req, merged[MSI_RNG_LSB+:3], s_q.pre))
          s_d.rsp.bresp = RESP_SLVERR;
        else
        begin
          s_d.osc_on = merged[OSC_ON_LSB+:NSRC];
          s_d.osc_on[s_d.sys_act] = 1'b1;
          s_d.msi_rng = merged[MSI_RNG_LSB+:3];
        end
      end
      else if (s_q.awaddr[11:2] == OFF_SYS[11:2])
      begin
        for (int i = 0; i < NBUS; i++)
          npre[i] = merged[SYS_PRE_LSB+SYS_PRE_STRIDE*i+:3];
        if (over_max(merged[SYS_SEL_LSB+:2], s_q.msi_rng, npre))
          s_d.rsp.bresp = RESP_SLVERR;
        else
        begin
          s_d.sys_req = merged[SYS_SEL_LSB+:2];
          s_d.pre = npre;
        end
      end
      else if (s_q.awaddr[11:2] == OFF_KSEL[11:2])
      begin
        for (int m = 0; m < NKMUX; m++)
          s_d.ksel_req[m] = merged[KSEL_W*m+:KSEL_W];
      end
      else if (s_q.awaddr[11:2] == OFF_MISC[11:2])
      begin
        s_d.adc_div = merged[MISC_ADCDIV_LSB+:2];
        s_d.dac_sh = merged[MISC_DACSH_BIT];
        s_d.st_cpu = merged[MISC_STCPU_BIT];
        s_d.sleep_en = merged[MISC_SE_LSB+:3];
      end
      else if (s_q.awaddr[11:2] != OFF_STAT[11:2])
        s_d.rsp.bresp = RESP_SLVERR;
    end

    if (axi_in.arvalid && s_q.rsp.arready)
    begin
      rd = reg_rd(s_q, axi_in.araddr, rdy, cpu_mode);
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rd[31:0];
      s_d.rsp.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end
    s_d.rsp.awready = !s_d.aw_hold && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_hold && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;

    if (!aresetn)
    begin
      s_d = '0;
      s_d.osc_on = RST_OSC_ON;
      s_d.msi_rng = RST_MSI_RNG;
      s_d.sys_req = SYS_MULTI;
      s_d.sys_act = SYS_MULTI;
    end
  end

  always_ff @(posedge aclk)
    s_q <= s_d;

  assign axi_out = s_q.rsp;
  assign ticks = s_q.ticks;
  assign osc_enable = s_q.osc_on;
  assign sys_src_active = s_q.sys_act;
  assign wake_ok = s_q.wake;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_boot_source: assert property ($rose(aresetn) |-> s_q.sys_act == SYS_MULTI && s_q.msi_rng == RST_MSI_RNG)
    else $error("boot source not multispeed at 4 MHz");
  chk_sys_switch: assert property ((s_q.sys_req != s_q.sys_act && rdy[s_q.sys_req])
                                   |=> s_q.sys_act == $past(s_q.sys_req))
    else $error("system switch missed a ready source");
  chk_active_on: assert property (s_q.osc_on[s_q.sys_act])
    else $error("active system source switched off");
  chk_bus_ceiling: assert property (!over_max(s_q.sys_req, s_q.msi_rng, s_q.pre))
    else $error("bus clock above ceiling");
  chk_rng_lowpower: assert property ((s_q.ticks.kern[K_RNG] && $past(cpu_mode) != MODE_RUN)
                                     |-> $past(s_q.ksel_act[K_RNG]) >= 3'h2)
    else $error("random clock from run-only source");
  chk_adc_run: assert property (s_q.ticks.kern[K_ADC] |-> $past(cpu_mode) == MODE_RUN)
    else $error("converter clock outside run");
  chk_adc_div4: assert property ((s_q.ticks.kern[K_ADC] && $past(s_q.ksel_act[K_ADC]) == 3'h3
                                  && $past(s_q.adc_div) == 2'h2) |-> $past(s_q.adc_cnt) == 2'h3)
    else $error("converter divide by four wrong");
  chk_dac_slow: assert property (s_q.ticks.dac == ($past(s_q.dac_sh) && $past(live[SRC_ISLOW])))
    else $error("dac tick not from slow oscillator");
  chk_ser_wake: assert property (s_q.wake[W_SER] |-> $past(s_q.ksel_act[K_SER]) inside {3'h1, 3'h2})
    else $error("serial wake with wrong clock");
  chk_aud_stop: assert property ((s_q.ticks.kern[K_AUD] && $past(cpu_mode) == MODE_STOP)
                                 |-> $past(s_q.ksel_act[K_AUD]) == 3'h2)
    else $error("audio clock in stop not from pin");
  chk_cal_div: assert property ((s_q.ticks.kern[K_CAL] && $past(s_q.ksel_act[K_CAL]) == 3'h2)
                                |-> $past(s_q.extf_cnt) == 5'h1f)
    else $error("calendar divide by 32 wrong");
  chk_wdg_slow: assert property (s_q.ticks.watchdog == $past(live[SRC_ISLOW]))
    else $error("watchdog tick not from slow oscillator");
  chk_system_tick_timer_div: assert property ((s_q.ticks.system_tick_timer_ref && !$past(s_q.st_cpu))
                                    |-> $past(bus_t[B_AHB1]) && $past(s_q.st_cnt) == 3'h7)
    else $error("system tick divide by eight wrong");

  cov_to_pll: cover property (s_q.sys_act == 2'h3 ##1 s_q.ticks.sys);
  cov_ser_stop: cover property (cpu_mode == MODE_STOP && s_q.wake[W_SER] ##1 s_q.ticks.kern[K_SER]);
  cov_refused: cover property (s_q.rsp.bvalid && s_q.rsp.bresp == RESP_SLVERR);

endmodule : clk_ctrl
